// File: pkg/amp_pkg.sv
/*
 Shared constants of the headphone amplifier control logic: bus address,
 register indices, field positions, power-up values, timing and gain table.
 Assumes a 100 MHz system clock.
*/
package amp_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h60;
   localparam logic [2:0] IDX_POWER = 3'h1;
   localparam logic [2:0] IDX_VOLUME = 3'h2;
   localparam logic [2:0] IDX_HIZ = 3'h3;
   localparam logic [2:0] IDX_ID = 3'h4;
   localparam logic [7:0] RST_POWER = 8'h01;
   localparam logic [7:0] RST_VOLUME = 8'hc0;
   localparam logic [7:0] RST_HIZ = 8'h00;
   // Arbitrary identification value
   localparam logic [7:0] ID_VALUE = 8'h5a;
   localparam int BIT_EN_L = 7;
   localparam int BIT_EN_R = 6;
   localparam int BIT_SHORT_L = 3;
   localparam int BIT_SHORT_R = 2;
   localparam int BIT_THERM = 1;
   localparam int BIT_SHUTDOWN = 0;
   localparam int BIT_MUTE_L = 7;
   localparam int BIT_MUTE_R = 6;
   localparam int VOL_LSB = 1;
   localparam int BIT_HIGH_IMPEDANCE_LEFT = 1;
   localparam int BIT_HIGH_IMPEDANCE_RIGHT = 0;
   localparam int CLK_MHZ = 100;
   localparam int DEPOP_MS = 12;
   localparam int STANDBY_US = 100;
   localparam int DEPOP_CYCLES = DEPOP_MS * 1000 * CLK_MHZ;
   localparam int STANDBY_CYCLES = STANDBY_US * CLK_MHZ;
   localparam logic [1:0] SHORT_HITS = 2'h3;
   // Gains in half-dB steps, two's complement; -80 dB does not fit in eight bits,
   // so mute takes a spare code that no volume step uses
   localparam logic [7:0] MUTE_GAIN_X2 = 8'h60;
   localparam logic [255:0] GAIN_TABLE_X2 = {
      8'h08, 8'h06, 8'h04, 8'h02, 8'h00, 8'hfe, 8'hfc, 8'hfa,
      8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hee, 8'hec, 8'hea,
      8'he6, 8'he2, 8'hde, 8'hda, 8'hd6, 8'hd2, 8'hce, 8'hca,
      8'hc2, 8'hba, 8'hb2, 8'haa, 8'ha2, 8'h9b, 8'h94, 8'h88};

   function automatic logic [7:0] gain_x2(input logic [4:0] code, input logic mute);
      return mute ? MUTE_GAIN_X2 : GAIN_TABLE_X2[{code, 3'h0} +: 8];
   endfunction
endpackage

// File: design/i2c_slave_engine.sv
/*
 Byte engine of the two-wire slave: start/stop detection, address match,
 acknowledge, receive and transmit shifting.
 Assumes the bus clock is far slower than clk; pins are asynchronous.
*/
module i2c_slave_engine
   import amp_pkg::*;
(
   input wire logic clk,           // system clock
   input wire logic rst_n,         // asynchronous reset
   input wire logic scl,           // bus clock pin level
   input wire logic sda_in,        // bus data pin level
   output logic sda_out,           // data pin drive value
   output logic sda_oe,            // high while pulling data low
   input wire logic [7:0] rd_data, // byte to send next
   output logic sub_stb,           // register address received
   output logic wr_stb,            // data byte received, eighth falling edge
   output logic rd_stb,            // rd_data taken
   output logic [7:0] rx_byte      // received byte
);
   typedef enum logic [3:0] {ST_IDLE, ST_DEV, ST_DEV_ACK, ST_SUB, ST_SUB_ACK,
                             ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} i2c_state_e;
   i2c_state_e state_r, state_nxt;
   logic [2:0] scl_sh_r, sda_sh_r;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic rw_r, rw_nxt, low_r, low_nxt, mack_r, mack_nxt;
   logic scl_rise, scl_fall, start_cond, stop_cond;

   // Bit 0 is the metastable stage; only bit 1 reads it
   assign scl_rise = scl_sh_r[1] & ~scl_sh_r[2];
   assign scl_fall = ~scl_sh_r[1] & scl_sh_r[2];
   assign start_cond = scl_sh_r[1] & scl_sh_r[2] & ~sda_sh_r[1] & sda_sh_r[2];
   assign stop_cond = scl_sh_r[1] & scl_sh_r[2] & sda_sh_r[1] & ~sda_sh_r[2];
   assign sda_out = 1'b0;
   assign sda_oe = low_r;
   assign rx_byte = shift_r;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      rw_nxt = rw_r;
      low_nxt = low_r;
      mack_nxt = mack_r;
      sub_stb = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      if (start_cond) begin
         state_nxt = ST_DEV;
         cnt_nxt = 4'h0;
         low_nxt = 1'b0;
      end else if (stop_cond) begin
         state_nxt = ST_IDLE;
         low_nxt = 1'b0;
      end else if (scl_rise) begin
         cnt_nxt = cnt_r + 4'h1;
         if (state_r inside {ST_DEV, ST_SUB, ST_WR}) begin
            shift_nxt = {shift_r[6:0], sda_sh_r[1]};
         end
         if (state_r == ST_RD_ACK) begin
            mack_nxt = ~sda_sh_r[1];
         end
      end else if (scl_fall) begin
         unique case (state_r)
            ST_IDLE: ;
            ST_DEV, ST_SUB, ST_WR: begin
               if (cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  low_nxt = 1'b1;
                  if (state_r == ST_DEV) begin
                     rw_nxt = shift_r[0];
                     state_nxt = ST_DEV_ACK;
                     if (shift_r[7:1] != DEV_ADDR) begin
                        state_nxt = ST_IDLE;
                        low_nxt = 1'b0;
                     end
                  end else if (state_r == ST_SUB) begin
                     sub_stb = 1'b1;
                     state_nxt = ST_SUB_ACK;
                  end else begin
                     wr_stb = 1'b1;
                     state_nxt = ST_WR_ACK;
                  end
               end
            end
            ST_DEV_ACK, ST_RD_ACK: begin
               cnt_nxt = 4'h0;
               if (state_r == ST_DEV_ACK && !rw_r) begin
                  state_nxt = ST_SUB;
                  low_nxt = 1'b0;
               end else if (state_r == ST_DEV_ACK || mack_r) begin
                  state_nxt = ST_RD;
                  shift_nxt = rd_data;
                  rd_stb = 1'b1;
                  low_nxt = ~rd_data[7];
               end else begin
                  state_nxt = ST_IDLE;
                  low_nxt = 1'b0;
               end
            end
            ST_SUB_ACK, ST_WR_ACK: begin
               cnt_nxt = 4'h0;
               state_nxt = ST_WR;
               low_nxt = 1'b0;
            end
            ST_RD: begin
               if (cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  low_nxt = 1'b0;
                  state_nxt = ST_RD_ACK;
               end else begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  low_nxt = ~shift_r[6];
               end
            end
            default: state_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sh_r <= 3'h7;
         sda_sh_r <= 3'h7;
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         rw_r <= 1'b0;
         low_r <= 1'b0;
         mack_r <= 1'b0;
      end else begin
         scl_sh_r <= {scl_sh_r[1:0], scl};
         sda_sh_r <= {sda_sh_r[1:0], sda_in};
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         rw_r <= rw_nxt;
         low_r <= low_nxt;
         mack_r <= mack_nxt;
      end
   end
endmodule

// File: design/power_sequencer.sv
/*
 Wake-up and standby timing of the amplifier supplies and outputs.
 Assumes cfg_stb pulses on the eighth falling edge of a power byte.
*/
module power_sequencer
   import amp_pkg::*;
#(
   parameter int unsigned DEPOP_CNT = DEPOP_CYCLES,
   parameter int unsigned STANDBY_CNT = STANDBY_CYCLES
) (
   input wire logic clk,         // system clock
   input wire logic rst_n,       // asynchronous reset
   input wire logic cfg_stb,     // power byte written
   input wire logic cfg_standby, // shutdown value of that byte
   input wire logic shutdown,    // current shutdown bit
   input wire logic thermal,     // over-temperature, synchronised
   output logic converters_on,   // supplies running
   output logic operational      // outputs may play
);
   typedef enum logic [1:0] {PW_OFF, PW_WAKE, PW_ON, PW_DOWN} pwr_state_e;
   localparam logic [20:0] DEPOP_LAST = 21'(DEPOP_CNT - 1);
   localparam logic [20:0] STANDBY_LAST = 21'(STANDBY_CNT - 1);
   pwr_state_e state_r, state_nxt;
   logic [20:0] cnt_r, cnt_nxt;
   logic hot_off_r, hot_off_nxt;

   assign converters_on = state_r != PW_OFF;
   assign operational = state_r == PW_ON;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r + 21'h1;
      hot_off_nxt = hot_off_r;
      if (thermal) begin
         state_nxt = PW_OFF;
         hot_off_nxt = 1'b1;
      end else begin
         unique case (state_r)
            PW_OFF: begin
               if ((cfg_stb && !cfg_standby) || (hot_off_r && !shutdown && !cfg_stb)) begin
                  state_nxt = PW_WAKE;
                  cnt_nxt = 21'h0;
                  hot_off_nxt = 1'b0;
               end
            end
            PW_WAKE, PW_ON: begin
               if (cfg_stb && cfg_standby) begin
                  state_nxt = PW_DOWN;
                  cnt_nxt = 21'h0;
               end else if (state_r == PW_WAKE && cnt_r == DEPOP_LAST) begin
                  state_nxt = PW_ON;
               end
            end
            PW_DOWN: begin
               if (cnt_r == STANDBY_LAST) begin
                  state_nxt = PW_OFF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= PW_OFF;
         cnt_r <= 21'h0;
         hot_off_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         hot_off_r <= hot_off_nxt;
      end
   end

   sequence wake_begins;
      state_r == PW_OFF ##1 state_r == PW_WAKE;
   endsequence

   AST_DEPOP_MUTED: assert property (@(posedge clk) disable iff (!rst_n)
      wake_begins |-> !operational [*8])
      else $error("outputs live too soon after wake start");
   AST_DEPOP_TIME: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(operational) |-> $past(cnt_r) == DEPOP_LAST && $past(state_r) == PW_WAKE)
      else $error("wake did not last the de-pop time");
   AST_STANDBY_TIME: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(converters_on) && !$past(thermal) |-> $past(cnt_r) == STANDBY_LAST)
      else $error("standby entry time wrong");
endmodule

// File: design/headphone_amp_control_regs.sv
/*
 Control and status registers of a stereo headphone amplifier reached over
 a two-wire slave bus, with short-circuit, thermal and output-mode logic.
 Assumes short checks arrive as strobes with a result level, and a thermal
 comparator level; all of them asynchronous to clk.
*/
// Behaviour
// - Short flag rises only after three consecutive detections on that channel.
// - Each short flag reads 0 normally and 1 after its channel shorted.
// - A flagged channel has its output stage put in high impedance.
// - Reading the power register returns short flags without clearing them.
// - Writing the power register clears both short flags and restores operation.
// - Over-temperature forces standby and sets the thermal flag; flag 0 otherwise.
// - Safe temperature again leaves thermal standby and clears the flag alone.
// - Shutdown bit 1 means shutdown; 0 turns on the supply converters.
// - Each channel enable bit turns on its own amplifier independently.
// - Volume code maps monotonically from -60 dB up to +4 dB.
// - Mute bit forces -80 dB gain; cleared, the volume gain applies.
// - High-impedance bit puts its own channel output in high impedance.
// - High impedance dominates; only active and enabled drives; else weak pulldown.
// - Wake-up starts on eighth falling clock edge of the power byte.
// - Outputs become live 12 ms after wake start, muted until then.
// - Standby begins on that eighth falling edge, complete 100 us later.
// - Power change is start, address, register, byte; address bytes acknowledged.
// - Slave address 1100000, direction bit last, most significant bit first.
// - Successive written bytes rotate through the three writable registers.
// - Successive read bytes cycle through all four registers.
// - Four readable registers; the fourth is read-only identification.
module headphone_amp_control_regs
   import amp_pkg::*;
#(
   parameter int unsigned DEPOP_CNT = DEPOP_CYCLES,
   parameter int unsigned STANDBY_CNT = STANDBY_CYCLES
) (
   input wire logic clk,               // system clock
   input wire logic rst_n,             // asynchronous reset, active low
   input wire logic scl,               // bus clock pin
   input wire logic sda_in,            // bus data pin level
   output logic sda_out,               // bus data drive value
   output logic sda_oe,                // high while driving data low
   input wire logic [1:0] short_check, // detection event strobe, [1] left
   input wire logic [1:0] short_hit,   // overcurrent seen at that event
   input wire logic thermal_hot,       // junction above limit
   output logic [1:0] amp_enable,      // amplifier bias on, [1] left
   output logic [1:0] out_hiz,         // output in high impedance
   output logic [1:0] out_drive,       // output actively driven
   output logic [1:0] out_pulldown,    // output weakly pulled down
   output logic [7:0] gain_left,       // left gain, half-dB, signed
   output logic [7:0] gain_right,      // right gain, half-dB, signed
   output logic converters_on,         // negative supply and buck running
   output logic operational            // de-pop finished
);
   logic sub_stb, wr_stb, rd_stb;
   logic [7:0] rx_byte, rd_data;
   logic [2:0] ptr_r, ptr_nxt;
   logic [1:0] en_r, en_nxt;
   logic shutdown_r, shutdown_nxt;
   logic [7:0] volume_r, volume_nxt;
   logic [1:0] high_impedance_right, hiz_nxt;
   logic [1:0] chk_meta_r, chk_sync_r, chk_prev_r, hit_meta_r, hit_sync_r;
   logic therm_meta_r, thermal_r;
   logic [1:0] chk_edge;
   wire [1:0] short_flag;
   logic power_wr;
   logic [1:0] amp_enable_nxt, out_hiz_nxt, out_drive_nxt, out_pulldown_nxt;
   logic [7:0] gain_left_nxt, gain_right_nxt;

   function automatic logic [2:0] next_ptr(input logic [2:0] p, input logic wr);
      if (wr ? (p >= IDX_HIZ) : (p >= IDX_ID)) begin
         return IDX_POWER;
      end
      return p + 3'h1;
   endfunction

   i2c_slave_engine u_bus (
      .clk(clk),
      .rst_n(rst_n),
      .scl(scl),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .rd_data(rd_data),
      .sub_stb(sub_stb),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb),
      .rx_byte(rx_byte)
   );

   power_sequencer #(
      .DEPOP_CNT(DEPOP_CNT),
      .STANDBY_CNT(STANDBY_CNT)
   ) u_power (
      .clk(clk),
      .rst_n(rst_n),
      .cfg_stb(power_wr),
      .cfg_standby(rx_byte[BIT_SHUTDOWN]),
      .shutdown(shutdown_r),
      .thermal(thermal_r),
      .converters_on(converters_on),
      .operational(operational)
   );

   assign power_wr = wr_stb && ptr_r == IDX_POWER;
   assign chk_edge = chk_sync_r & ~chk_prev_r;

   // Read path; reads have no side effect on the flags
   always_comb begin
      unique case (ptr_r)
         IDX_POWER: rd_data = {en_r[1], en_r[0], 2'b00, short_flag[1],
                               short_flag[0], thermal_r, shutdown_r};
         IDX_VOLUME: rd_data = {volume_r[7:1], 1'b0};
         IDX_HIZ: rd_data = {6'h00, high_impedance_right};
         IDX_ID: rd_data = ID_VALUE;
         default: rd_data = 8'h00;
      endcase
   end

   // Register file and address pointer
   always_comb begin
      ptr_nxt = ptr_r;
      en_nxt = en_r;
      shutdown_nxt = shutdown_r;
      volume_nxt = volume_r;
      hiz_nxt = high_impedance_right;
      if (sub_stb) begin
         ptr_nxt = rx_byte[2:0];
      end else if (wr_stb) begin
         ptr_nxt = next_ptr(ptr_r, 1'b1);
         unique case (ptr_r)
            IDX_POWER: begin
               en_nxt = {rx_byte[BIT_EN_L], rx_byte[BIT_EN_R]};
               shutdown_nxt = rx_byte[BIT_SHUTDOWN];
            end
            IDX_VOLUME: volume_nxt = {rx_byte[7:1], 1'b0};
            IDX_HIZ: hiz_nxt = {rx_byte[BIT_HIGH_IMPEDANCE_LEFT], rx_byte[BIT_HIGH_IMPEDANCE_RIGHT]};
            default: ; // The identification register ignores writes
         endcase
      end else if (rd_stb) begin
         ptr_nxt = next_ptr(ptr_r, 1'b0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_r <= IDX_POWER;
         en_r <= {RST_POWER[BIT_EN_L], RST_POWER[BIT_EN_R]};
         shutdown_r <= RST_POWER[BIT_SHUTDOWN];
         volume_r <= RST_VOLUME;
         high_impedance_right <= RST_HIZ[1:0];
      end else begin
         ptr_r <= ptr_nxt;
         en_r <= en_nxt;
         shutdown_r <= shutdown_nxt;
         volume_r <= volume_nxt;
         high_impedance_right <= hiz_nxt;
      end
   end

   // Pin-side status inputs pass two flip-flops first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_meta_r <= 2'h0;
         chk_sync_r <= 2'h0;
         chk_prev_r <= 2'h0;
         hit_meta_r <= 2'h0;
         hit_sync_r <= 2'h0;
         therm_meta_r <= 1'b0;
         thermal_r <= 1'b0;
      end else begin
         chk_meta_r <= short_check;
         chk_sync_r <= chk_meta_r;
         chk_prev_r <= chk_sync_r;
         hit_meta_r <= short_hit;
         hit_sync_r <= hit_meta_r;
         therm_meta_r <= thermal_hot;
         thermal_r <= therm_meta_r;
      end
   end

   // Short detection per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_short
      logic [1:0] cnt_r, cnt_nxt;
      logic flag_r, flag_nxt;

      always_comb begin
         cnt_nxt = cnt_r;
         flag_nxt = flag_r;
         if (power_wr) begin
            cnt_nxt = 2'h0;
            flag_nxt = 1'b0;
         end
         // A detection in the clearing cycle still counts: set beats clear
         if (chk_edge[ch]) begin
            if (!hit_sync_r[ch]) begin
               cnt_nxt = 2'h0;
            end else if (cnt_r == SHORT_HITS - 2'h1) begin
               cnt_nxt = 2'h0;
               flag_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 2'h1;
            end
         end
      end

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cnt_r <= 2'h0;
            flag_r <= 1'b0;
         end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
         end
      end

      assign short_flag[ch] = flag_r;
   end

   // Output stage state per channel
   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         out_hiz_nxt[ch] = high_impedance_right[ch] | short_flag[ch];
         out_drive_nxt[ch] = !out_hiz_nxt[ch] && !shutdown_r && en_r[ch]
                             && operational;
         out_pulldown_nxt[ch] = !out_hiz_nxt[ch] && !out_drive_nxt[ch];
         amp_enable_nxt[ch] = en_r[ch] && converters_on;
      end
      // Muted until de-pop is over so the turn-on stays silent
      gain_left_nxt = gain_x2(volume_r[5:1],
                              volume_r[BIT_MUTE_L] || !operational);
      gain_right_nxt = gain_x2(volume_r[5:1],
                               volume_r[BIT_MUTE_R] || !operational);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_hiz <= 2'h0;
         out_drive <= 2'h0;
         out_pulldown <= 2'h3;
         amp_enable <= 2'h0;
         gain_left <= MUTE_GAIN_X2;
         gain_right <= MUTE_GAIN_X2;
      end else begin
         out_hiz <= out_hiz_nxt;
         out_drive <= out_drive_nxt;
         out_pulldown <= out_pulldown_nxt;
         amp_enable <= amp_enable_nxt;
         gain_left <= gain_left_nxt;
         gain_right <= gain_right_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence third_hit_left;
      chk_edge[1] && hit_sync_r[1] && g_short[1].cnt_r == 2'h2;
   endsequence

   AST_SHORT_AFTER_THREE: assert property (
      $rose(short_flag[1]) |-> $past(g_short[1].cnt_r) == 2'h2
         && $past(chk_edge[1] && hit_sync_r[1]))
      else $error("short flag rose without three hits");
   AST_SHORT_THIRD_SETS: assert property (third_hit_left |=> short_flag[1])
      else $error("third hit did not raise short flag");
   AST_SHORT_HIZ: assert property (short_flag[0] |=> out_hiz[0] && !out_drive[0])
      else $error("shorted channel not in high impedance");
   AST_SHORT_HOLD: assert property (short_flag[0] && !power_wr |=> short_flag[0])
      else $error("short flag lost without a power write");
   AST_SHORT_CLEAR: assert property (power_wr && !chk_edge[1] |=> !short_flag[1])
      else $error("power write did not clear short flag");
   AST_THERMAL_OFF: assert property (thermal_r |=> !converters_on ##1 !out_drive[0])
      else $error("over-temperature did not force standby");
   AST_THERMAL_BACK: assert property (
      $fell(thermal_r) && !shutdown_r && !power_wr |=> converters_on)
      else $error("no recovery after over-temperature");
   AST_SHUTDOWN_SILENT: assert property (shutdown_r [*2] |=> out_drive == 2'h0)
      else $error("output driven during software shutdown");
   AST_HIZ_DOMINATES: assert property (high_impedance_right[1] |=> out_hiz[1] && !out_pulldown[1])
      else $error("high impedance bit not obeyed");
   AST_MUTE_GAIN: assert property (volume_r[BIT_MUTE_R] |=> gain_right == MUTE_GAIN_X2)
      else $error("mute did not force minimum gain");
   AST_WRITE_WRAP: assert property (wr_stb && ptr_r == IDX_HIZ |=> ptr_r == IDX_POWER)
      else $error("write pointer did not wrap to first register");
   AST_READ_WRAP: assert property (rd_stb && ptr_r == IDX_ID |=> ptr_r == IDX_POWER)
      else $error("read pointer did not wrap after fourth register");
endmodule

// File: testbench/i2c_host.sv
/* Bus master model for the amplifier's two-wire port.
 Assumes the bench resolves the pulled-up data line. */
module i2c_host
   import amp_pkg::*;
(
   input wire logic clk, // system clock
   output logic scl,     // bus clock, idle high
   output logic m_oe,    // high while pulling data low
   input wire logic sda  // resolved data line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bit of 80 ns; sampled late in the high phase, as the slave answers slowly
   task automatic bitx(input logic b, output logic r);
      clks(2);
      m_oe <= ~b;
      clks(2);
      scl <= 1'b1;
      clks(4);
      r = sda;
      scl <= 1'b0;
   endtask
   task automatic start;
      clks(2);
      m_oe <= 1'b0;
      clks(2);
      scl <= 1'b1;
      clks(4);
      m_oe <= 1'b1;
      clks(4);
      scl <= 1'b0;
   endtask
   task automatic stop;
      clks(2);
      m_oe <= 1'b1;
      clks(2);
      scl <= 1'b1;
      clks(4);
      m_oe <= 1'b0;
      clks(4);
   endtask
   task automatic xb(input logic [7:0] b, input logic last, output logic [7:0] q,
         output logic a);
      for (int i = 7; i >= 0; i--) bitx(b[i], q[i]);
      bitx(last, a);
   endtask
   task automatic wr(input logic [7:0] r, input logic [23:0] d, input int n,
         output logic nak);
      logic [7:0] q;
      logic a;
      start();
      xb({DEV_ADDR, 1'b0}, 1'b1, q, nak);
      xb(r, 1'b1, q, a);
      nak = nak | a;
      for (int k = n - 1; k >= 0; k--) xb(d[8*k+:8], 1'b1, q, a);
      stop();
   endtask
   task automatic rd(input logic [7:0] r, input int n, output logic [31:0] d);
      logic [7:0] q;
      logic a;
      start();
      xb({DEV_ADDR, 1'b0}, 1'b1, q, a);
      xb(r, 1'b1, q, a);
      start();
      xb({DEV_ADDR, 1'b1}, 1'b1, q, a);
      d = '0;
      for (int k = 1; k <= n; k++) begin
         xb(8'hff, k == n, q, a);
         d = {d[23:0], q};
      end
      stop();
   endtask
endmodule

// File: testbench/tb.sv
/* Self-checking bench of the amplifier control registers.
 Assumes a bus master model and shortened power delays. */
module tb
   import amp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, thermal_hot = 0, scl, m_oe, sda_oe, nak, conv, oper;
   logic [1:0] short_check = 0, short_hit = 0, amp_en, high_impedance_bit, drv, pd;
   logic [7:0] gl, gr;
   logic [31:0] q;
   int err_total = 0, tests_run = 0;
   wire sda = ~(sda_oe | m_oe);
   always #5 clk = ~clk;
   headphone_amp_control_regs #(.DEPOP_CNT(40), .STANDBY_CNT(20)) u_headphone_amp_control_regs (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .short_check(short_check), .short_hit(short_hit), .thermal_hot(thermal_hot),
      .amp_enable(amp_en), .out_hiz(high_impedance_bit), .out_drive(drv), .out_pulldown(pd),
      .gain_left(gl), .gain_right(gr), .converters_on(conv), .operational(oper));
   i2c_host u_i2c_host (.clk(clk), .scl(scl), .m_oe(m_oe), .sda(sda));
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic summarize;
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic hit(logic [1:0] m, int n);
      repeat (n) begin
         @(posedge clk) short_check <= m;
         short_hit <= m;
         repeat (4) @(posedge clk);
         short_check <= 2'b00;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic t_reset;
      u_i2c_host.rd(8'h01, 4, q);
      chk("regs", q, {RST_POWER, RST_VOLUME, RST_HIZ, ID_VALUE});
      chk("mute", gl, MUTE_GAIN_X2);
   endtask
   task automatic t_wake;
      u_i2c_host.wr(8'h01, 24'hc0, 1, nak);
      chk("ack", nak, 0);
      chk("depop", {oper, gr}, {1'b0, MUTE_GAIN_X2});
      repeat (40) @(posedge clk);
      chk("live", {oper, conv, amp_en}, 4'hf);
      u_i2c_host.wr(8'h02, 24'h3602, 2, nak);
      chk("gain", {gl, gr}, 16'h0);
      chk("mode", {high_impedance_bit, drv, pd}, 6'b100100);
   endtask
   task automatic t_short;
      hit(2'b11, 2);
      u_i2c_host.rd(8'h01, 1, q);
      chk("two", q, 32'hc0);
      hit(2'b01, 1);
      repeat (2) begin
         u_i2c_host.rd(8'h01, 1, q);
         chk("flag", q, 32'hc4);
      end
      hit(2'b10, 1);
      u_i2c_host.rd(8'h01, 1, q);
      chk("both", q, 32'hcc);
      chk("shz", high_impedance_bit, 2'b11);
      u_i2c_host.wr(8'h01, 24'hc0, 1, nak);
      u_i2c_host.rd(8'h01, 1, q);
      chk("clr", {high_impedance_bit, q[7:0]}, 10'h2c0);
   endtask
   task automatic t_thermal;
      @(posedge clk) thermal_hot <= 1'b1;
      repeat (10) @(posedge clk);
      u_i2c_host.rd(8'h01, 1, q);
      chk("hot", {conv, q[7:0]}, 9'h0c2);
      thermal_hot <= 1'b0;
      repeat (10) @(posedge clk);
      u_i2c_host.rd(8'h01, 1, q);
      chk("cool", {conv, q[7:0]}, 9'h1c0);
   endtask
   task automatic t_standby;
      u_i2c_host.wr(8'h01, 24'h01, 1, nak);
      repeat (30) @(posedge clk);
      chk("stby", {conv, high_impedance_bit, drv, pd}, 7'b0100001);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_wake();
      t_short();
      t_thermal();
      t_standby();
      summarize();
   end
   initial begin
      #500us;
      err_total++;
      summarize();
   end
endmodule
